// ===== core/uib_regs.sv
// banked configuration registers of the infrared serial port, AXI4-Lite slave
//
// Contract
// [RQ1] receive level reads byte count in bits 4:0, upper bits zero, read-only
// [RQ2] software reads level three times, uses second if first two match
// [RQ3] bank three decodes id, line shadow, fifo shadow, shared 03h, reserved
// [RQ4] id register read-only: module type upper nibble, revision lower
// [RQ5] line shadow returns line control, updated by 03h write in any bank
// [RQ6] fifo shadow is read-only, returns last bank-0 fifo control write
// [RQ7] offset 03h in every bank reaches the shared line/bank select
// [RQ8] bank four bits 3:2 select serial, reserved, carrier IR or SIR
// [RQ9] extended operation ignores the non-extended mode select bits
// [RQ10] full-duplex bit 0 keeps receiver live; otherwise masked while sending
// [RQ11] IR mode with select set: modem status reads 30h, interrupt off
// [RQ12] bank five bit 4 routes receive path from auxiliary input
// [RQ13] bank six bit 6 low applies 500 kHz modulation in carrier mode
// [RQ14] bank six bit 7 low demodulates 500 kHz carrier on receive
// [RQ15] pulse code 0000 gives 3/16 bit, 1101 gives 1.6 us
// [RQ16] pulse width setting affects only transmit, never reception
// [RQ17] software writes zero to reserved offsets and reserved bits
// [RQ18] loopback in IR mode keeps modem interrupt off unless select is 0
// [RQ19] reserved offsets and bits read zero, writes to them are dropped; bank six offset 00h reads bit 5 set from reset until written
`timescale 1ns/1ps
`include "uib_cfg.svh"
module uib_regs
  import uib_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // AXI4-Lite slave
  input wire logic [`UIB_ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [`UIB_ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // status from the serial core
  input wire logic [`UIB_LVL_W-1:0] RX_LEVEL_I,
  input wire logic [`UIB_LVL_W-1:0] TX_LEVEL_I,
  input wire logic EXT_MODE_I,
  input wire logic [1:0] EXT_IR_MODE_I,
  input wire logic LOOPBACK_I,
  input wire logic [7:0] MODEM_STATUS_I,
  input wire logic TX_ACTIVE_I,
  input wire logic IR_RX_PRI_I,
  input wire logic IR_RX_AUX_I,
  // controls toward the infrared path
  output logic [1:0] IR_MODE_O,
  output logic CARRIER_MOD_EN_O,
  output logic CARRIER_DEMOD_EN_O,
  output logic SIR_PULSE_WIDTH_CONTROL_1U6_O,
  output logic [7:0] MSR_VALUE_O,
  output logic MS_INT_EN_O,
  output logic IR_RX_O,
  output logic [2:0] BANK_O,
  output logic [7:0] LINE_CONTROL_O
);

  // ==========================================================
  // bus handshake state
  // timing seen from the bus: the write answer comes two edges after both
  // halves arrive together, read data one edge after the address is taken;
  // readies stay low after each take until the answer is taken, so a master must wait on
  // them and never assume a fixed latency
  logic awrdy_r, wrdy_r, bvalid_r, arrdy_r, rvalid_r;
  logic aw_have_r, w_have_r;
  logic [`UIB_IDX_W-1:0] aw_idx_r;
  logic aw_bad_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_hs, w_hs, ar_hs, do_write;

  assign aw_hs = AWVALID_I & awrdy_r;
  assign w_hs = WVALID_I & wrdy_r;
  assign ar_hs = ARVALID_I & arrdy_r;
  assign do_write = aw_have_r & w_have_r & ~bvalid_r;

  // ==========================================================
  // register state
  logic [7:0] lcr_r, fcr_r, leg_r, basic_r, phys_r, pw_code_r;
  uib_bank_t bank_r;
  logic wr_en;
  logic [`UIB_IDX_W-1:0] wi;

  // a write with byte lane 0 off or outside the window touches nothing
  assign wr_en = do_write & wlane_r & ~aw_bad_r;
  assign wi = aw_idx_r;

  // ==========================================================
  // write address channel: address and data accepted in either order
  // ready is withheld while an address is held or an answer waits; this
  // keeps one write in flight without a separate state machine
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      awrdy_r <= 1'b0;
      aw_have_r <= 1'b0;
      aw_idx_r <= `UIB_OFS_00;
      aw_bad_r <= 1'b0;
    end
    else
    begin
      awrdy_r <= ~aw_have_r & ~aw_hs & ~bvalid_r;
      if (aw_hs)
      begin
        aw_have_r <= 1'b1;
        aw_idx_r <= AWADDR_I[`UIB_IDX_LSB +: `UIB_IDX_W];
        aw_bad_r <= |AWADDR_I[`UIB_ADDR_W-1:`UIB_IDX_LSB+`UIB_IDX_W];
      end
      else if (do_write)
        aw_have_r <= 1'b0;
    end
  end

  // write data channel, only the low byte matters
  // every register is one byte wide, so a write with lane 0 off is
  // answered okay but changes nothing
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wrdy_r <= 1'b0;
      w_have_r <= 1'b0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end
    else
    begin
      wrdy_r <= ~w_have_r & ~w_hs & ~bvalid_r;
      if (w_hs)
      begin
        w_have_r <= 1'b1;
        wbyte_r <= WDATA_I[7:0];
        wlane_r <= WSTRB_I[0];
      end
      else if (do_write)
        w_have_r <= 1'b0;
    end
  end

  // write response, held until the master takes it
  // a refused address still gets an answer, so the master never hangs
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `UIB_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= aw_bad_r ? `UIB_RESP_DECERR : `UIB_RESP_OKAY;
    end
    else if (bvalid_r & BREADY_I)
      bvalid_r <= 1'b0;
  end

  // ==========================================================
  // shared line-control / bank-select location, reached from any bank
  // a bank-select value leaves line control alone, so the shadow keeps
  // showing the last real line setting
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      lcr_r <= `UIB_LCR_RST;
      bank_r <= `UIB_BANK_0;
    end
    else if (wr_en && wi == `UIB_OFS_03) // RQ7
    begin
      if (!wbyte_r[`UIB_LCR_SEL_BIT])
      begin
        lcr_r <= wbyte_r; // RQ5
        bank_r <= `UIB_BANK_0;
      end
      else if (wbyte_r[`UIB_BANK_KEY_HI:`UIB_BANK_KEY_LO] == `UIB_BANK_KEY)
        bank_r <= wbyte_r[`UIB_BANK_FLD_HI:`UIB_BANK_FLD_LO];
      else
      begin
        // divisor latch access style value: line control and bank one
        lcr_r <= wbyte_r; // RQ5
        bank_r <= `UIB_BANK_1;
      end
    end
  end

  // banked registers; reserved bits masked off, reserved offsets ignored
  // the shadow offsets of bank three have no write arm, so they stay
  // read-only without a separate guard
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      fcr_r <= `UIB_FCR_RST;
      leg_r <= `UIB_LEG_RST;
      basic_r <= `UIB_BASIC_RST;
      phys_r <= `UIB_PHYS_RST;
      pw_code_r <= `UIB_PWC_RST;
    end
    else if (wr_en)
    begin
      if (bank_r == `UIB_BANK_0 && wi == `UIB_OFS_02)
        fcr_r <= wbyte_r; // RQ6
      if (bank_r == `UIB_BANK_4 && wi == `UIB_OFS_02)
        leg_r <= wbyte_r & `UIB_LEG_MASK; // RQ19
      if (bank_r == `UIB_BANK_5 && wi == `UIB_OFS_04)
        basic_r <= wbyte_r & `UIB_BASIC_MASK; // RQ19
      if (bank_r == `UIB_BANK_6 && wi == `UIB_OFS_00)
        phys_r <= wbyte_r & `UIB_PHYS_MASK; // RQ19
      if (bank_r == `UIB_BANK_6 && wi == `UIB_OFS_02)
        pw_code_r <= wbyte_r & `UIB_PWC_MASK; // RQ19
    end
  end

  // ==========================================================
  // read decode; levels are not frozen, so software must filter them
  // latching the levels would cost a copy per read and still not give a
  // coherent count while traffic runs, so they pass straight through
  function automatic logic [7:0] rd_mux(input uib_bank_t bk,
                                        input logic [`UIB_IDX_W-1:0] ix);
    logic [7:0] v;
    v = 8'h00; // RQ19
    if (ix == `UIB_OFS_03)
      v = (bk == `UIB_BANK_0) ? lcr_r : {`UIB_BANK_KEY, 2'b00, bk}; // RQ7
    else
      case (bk)
        `UIB_BANK_2:
        begin
          if (ix == `UIB_OFS_07)
            v = {3'h0, RX_LEVEL_I}; // RQ1
          else if (ix == `UIB_OFS_06)
            v = {3'h0, TX_LEVEL_I};
        end
        `UIB_BANK_3:
        begin
          case (ix) // RQ3
            `UIB_OFS_00: v = {`UIB_MOD_TYPE, `UIB_MOD_REV}; // RQ4
            `UIB_OFS_01: v = lcr_r; // RQ5
            `UIB_OFS_02: v = fcr_r; // RQ6
            default: v = 8'h00;
          endcase
        end
        `UIB_BANK_4: if (ix == `UIB_OFS_02) v = leg_r; // RQ8
        `UIB_BANK_5: if (ix == `UIB_OFS_04) v = basic_r;
        `UIB_BANK_6:
        begin
          if (ix == `UIB_OFS_00)
            v = phys_r;
          else if (ix == `UIB_OFS_02)
            v = pw_code_r;
        end
        default: v = 8'h00;
      endcase
    return v;
  endfunction

  // read channel: data appears the cycle after the address is taken
  // the bank is taken as it stands at the address edge; a bank change
  // still in flight on the write side is seen by the next read
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      arrdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `UIB_RESP_OKAY;
    end
    else
    begin
      arrdy_r <= ~rvalid_r & ~ar_hs;
      if (ar_hs)
      begin
        rvalid_r <= 1'b1;
        if (|ARADDR_I[`UIB_ADDR_W-1:`UIB_IDX_LSB+`UIB_IDX_W])
        begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `UIB_RESP_DECERR;
        end
        else
        begin
          rdata_r <= {24'h00_0000,
                      rd_mux(bank_r, ARADDR_I[`UIB_IDX_LSB +: `UIB_IDX_W])};
          rresp_r <= `UIB_RESP_OKAY;
        end
      end
      else if (rvalid_r & RREADY_I)
        rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // infrared controls derived from the registers
  uib_ir_ctrl_t ctl_nxt, ctl_r;
  logic ir_rx_nxt, ir_rx_r;
  logic [7:0] msr_nxt, msr_r;

  always_comb
  begin
    // extended operation owns the mode; legacy bits are ignored then
    ctl_nxt.mode = EXT_MODE_I ? EXT_IR_MODE_I :
                   leg_r[`UIB_LEG_SEL_HI:`UIB_LEG_SEL_LO]; // RQ8 RQ9
    ctl_nxt.carrier_mod_en = (ctl_nxt.mode == `UIB_MODE_CARRIER) &
                             ~phys_r[`UIB_MOD_DS_BIT]; // RQ13
    ctl_nxt.carrier_demod_en = (ctl_nxt.mode == `UIB_MODE_CARRIER) &
                               ~phys_r[`UIB_DEM_DS_BIT]; // RQ14
    // reserved codes fall back to 3/16; receive detection never sees this
    ctl_nxt.sir_pulse_width_control_1u6 = (pw_code_r[`UIB_PWC_HI:`UIB_PWC_LO] ==
                          `UIB_PWC_1U6); // RQ15 RQ16
    ctl_nxt.rx_masked = TX_ACTIVE_I & ~basic_r[`UIB_FDPLX_BIT]; // RQ10
    // loopback swaps the modem sources upstream and keeps this gate, so
    // the loopback flag itself is not needed here; modem events stay
    // silent in infrared modes until the select bit is cleared
    ctl_nxt.ms_int_en = ~((ctl_nxt.mode != `UIB_MODE_SERIAL) &
                          basic_r[`UIB_MSSEL_BIT]); // RQ11 RQ18
    msr_nxt = ctl_nxt.ms_int_en ? MODEM_STATUS_I : `UIB_MSR_MASKED; // RQ11
    // masked receive idles low; aux select picks the front end
    ir_rx_nxt = ~ctl_nxt.rx_masked &
                (basic_r[`UIB_AUX_BIT] ? IR_RX_AUX_I : IR_RX_PRI_I); // RQ12
  end

  // outputs registered: one cycle of latency on every control
  // the registered copy keeps every output straight from a flop; the
  // serial core absorbs the extra cycle easily
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ctl_r <= '0;
      msr_r <= 8'h00;
      ir_rx_r <= 1'b0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      msr_r <= msr_nxt;
      ir_rx_r <= ir_rx_nxt;
    end
  end

  // ==========================================================
  // port drive
  assign AWREADY_O = awrdy_r;
  assign WREADY_O = wrdy_r;
  assign BVALID_O = bvalid_r;
  assign BRESP_O = bresp_r;
  assign ARREADY_O = arrdy_r;
  assign RVALID_O = rvalid_r;
  assign RDATA_O = rdata_r;
  assign RRESP_O = rresp_r;
  assign IR_MODE_O = ctl_r.mode;
  assign CARRIER_MOD_EN_O = ctl_r.carrier_mod_en;
  assign CARRIER_DEMOD_EN_O = ctl_r.carrier_demod_en;
  assign SIR_PULSE_WIDTH_CONTROL_1U6_O = ctl_r.sir_pulse_width_control_1u6;
  assign MS_INT_EN_O = ctl_r.ms_int_en;
  assign MSR_VALUE_O = msr_r;
  assign IR_RX_O = ir_rx_r;
  assign BANK_O = bank_r;
  assign LINE_CONTROL_O = lcr_r;

endmodule

// ===== core/uib_cfg.svh
// constants of the infrared serial register bank
`ifndef UIB_CFG_SVH
`define UIB_CFG_SVH
// register index within the eight-word window (byte address = index * 4)
`define UIB_IDX_W 3
`define UIB_ADDR_W 8
`define UIB_IDX_LSB 2
`define UIB_OFS_00 3'h0
`define UIB_OFS_01 3'h1
`define UIB_OFS_02 3'h2
`define UIB_OFS_03 3'h3
`define UIB_OFS_04 3'h4
`define UIB_OFS_06 3'h6
`define UIB_OFS_07 3'h7
// banks
`define UIB_BANK_0 3'h0
`define UIB_BANK_1 3'h1
`define UIB_BANK_2 3'h2
`define UIB_BANK_3 3'h3
`define UIB_BANK_4 3'h4
`define UIB_BANK_5 3'h5
`define UIB_BANK_6 3'h6
// shared location decode: bit 7 low is a line-control write
`define UIB_LCR_SEL_BIT 7
`define UIB_BANK_KEY 3'h7
`define UIB_BANK_KEY_HI 7
`define UIB_BANK_KEY_LO 5
`define UIB_BANK_FLD_HI 2
`define UIB_BANK_FLD_LO 0
// reset values
`define UIB_LCR_RST 8'h00
`define UIB_FCR_RST 8'h00
`define UIB_LEG_RST 8'h00
`define UIB_BASIC_RST 8'h02
`define UIB_PHYS_RST 8'h20
`define UIB_PWC_RST 8'h00
// writable bit masks, writes zero reserved bits; UIB_PHYS_RST sets bit 5 until the first write
`define UIB_LEG_MASK 8'h0c
`define UIB_BASIC_MASK 8'h13
`define UIB_PHYS_MASK 8'hc0
`define UIB_PWC_MASK 8'h0f
// field positions
`define UIB_LEG_SEL_HI 3
`define UIB_LEG_SEL_LO 2
`define UIB_FDPLX_BIT 0
`define UIB_MSSEL_BIT 1
`define UIB_AUX_BIT 4
`define UIB_MOD_DS_BIT 6
`define UIB_DEM_DS_BIT 7
`define UIB_LVL_W 5
`define UIB_PWC_HI 3
`define UIB_PWC_LO 0
// interface mode codes
`define UIB_MODE_SERIAL 2'b00
`define UIB_MODE_CARRIER 2'b10
`define UIB_MODE_SIR 2'b11
// pulse width codes and masked modem status value
`define UIB_PWC_316 4'h0
`define UIB_PWC_1U6 4'hd
`define UIB_MSR_MASKED 8'h30
// identity nibbles, values arbitrary
`define UIB_MOD_TYPE 4'h9
`define UIB_MOD_REV 4'h1
// bus answers
`define UIB_RESP_OKAY 2'b00
`define UIB_RESP_DECERR 2'b11
`endif

// ===== core/uib_pkg.sv
// types of the infrared serial register bank
package uib_pkg;
  typedef logic [2:0] uib_bank_t;
  typedef struct packed {
    logic [1:0] mode;
    logic carrier_mod_en;
    logic carrier_demod_en;
    logic sir_pulse_width_control_1u6;
    logic rx_masked;
    logic ms_int_en;
  } uib_ir_ctrl_t;
  typedef enum logic [1:0] {
    UIB_PW_316 = 2'b00,
    UIB_PW_1U6 = 2'b01
  } uib_pw_t;
endpackage

// ===== dv/uib_regs_sva.sv
// port assertions for the infrared register bank
`timescale 1ns/1ps
module uib_regs_sva (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [7:0] MODEM_STATUS_I,
  input wire logic EXT_MODE_I,
  input wire logic [1:0] EXT_IR_MODE_I,
  input wire logic IR_RX_PRI_I,
  input wire logic IR_RX_AUX_I,
  input wire logic [1:0] IR_MODE_O,
  input wire logic CARRIER_MOD_EN_O,
  input wire logic CARRIER_DEMOD_EN_O,
  input wire logic [7:0] MSR_VALUE_O,
  input wire logic MS_INT_EN_O,
  input wire logic IR_RX_O
);
  logic up_r;
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  // ==========
  // helper
  // high from the second edge after reset, so $past never sees reset
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
    if (!NRST_I)
      up_r <= 1'b0;
    else
      up_r <= 1'b1;
  // ==========
  // assertions
  a_wr_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I
    && WREADY_O |-> ##2 BVALID_O) else $error("no write answer");
  a_rd_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("no read answer");
  a_unmapped_rd: assert property (ARVALID_I && ARREADY_O
    && ARADDR_I[7:5] != 3'h0 |=> RRESP_O == 2'b11 && RDATA_O == 32'h0)
    else $error("unmapped read answer wrong");
  a_r_hold: assert property (RVALID_O && !RREADY_I
    |=> RVALID_O && $stable(RDATA_O)) else $error("read data dropped");
  a_ext_mode: assert property (up_r && $past(EXT_MODE_I)
    |-> IR_MODE_O == $past(EXT_IR_MODE_I)) else $error("ext mode lost");
  a_ms_off: assert property (up_r && !MS_INT_EN_O
    |-> MSR_VALUE_O == 8'h30 && IR_MODE_O != 2'b00)
    else $error("modem interrupt off wrongly");
  a_ms_pass: assert property (up_r && MS_INT_EN_O
    |-> MSR_VALUE_O == $past(MODEM_STATUS_I)) else $error("msr not raw");
  a_rx_src: assert property (up_r && IR_RX_O
    |-> $past(IR_RX_PRI_I) || $past(IR_RX_AUX_I))
    else $error("rx from nowhere");
  a_mod_mode: assert property (CARRIER_MOD_EN_O
    |-> IR_MODE_O == 2'b10) else $error("modulation outside carrier");
  a_dem_mode: assert property (CARRIER_DEMOD_EN_O
    |-> IR_MODE_O == 2'b10) else $error("demod outside carrier");
endmodule
bind uib_regs uib_regs_sva i_sva (.*);

// ===== dv/uib_ir_front.sv
// infrared transceiver front end model driving both receive lines
`timescale 1ns/1ps
module uib_ir_front (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic pri_o,
  output logic aux_o
);
  logic [1:0] cnt_r;
  // ==========
  // pulse patterns
  // lines differ in rate so a wrong receive route shows up
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  assign pri_o = cnt_r[0];
  assign aux_o = cnt_r[1];
endmodule

// ===== dv/uib_regs_tb.sv
// self-checking bench for the infrared register bank
`timescale 1ns/1ps
module uib_regs_tb;
  import uib_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
  logic ar_v = 1'b0, r_r = 1'b0, ext = 1'b0, txa = 1'b0, pri, aux;
  logic pri_q, aux_q, aw_rdy, w_rdy, bv, ar_rdy, rv, mod_en, dem_en;
  logic pw, msi_en, irx, lpb = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, msi = 8'ha5, modem_status_register, line_control_register;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] extm = 2'b01, bresp, rresp, mode;
  logic [4:0] rxl = 5'h13;
  logic [3:0] stb = 4'h1;
  logic [2:0] bank;
  int mismatches = 0, num_checks = 0, cyc = 0;
  // bit 16 write, 15:8 address, 7:0 data or expected read
  logic [16:0] tbl [0:37] = '{17'h00c00, 17'h10ce6, 17'h00020, 17'h00800,
    17'h100ff, 17'h000c0, 17'h108fd, 17'h0080d, 17'h00ce6, 17'h10ce5,
    17'h01002, 17'h110ff, 17'h01013, 17'h10ce4, 17'h00800, 17'h108ff,
    17'h0080c, 17'h00000, 17'h10ce3, 17'h00091, 17'h10055, 17'h00091,
    17'h10c1b, 17'h10847, 17'h10ce3, 17'h0041b, 17'h00847, 17'h108aa,
    17'h00847, 17'h10ce5, 17'h10c3a, 17'h10ce3, 17'h0043a, 17'h10ce2,
    17'h01c13, 17'h0180c, 17'h12011, 17'h02000};
  uib_regs i_dut (.REF_CLK_I(clk), .NRST_I(nrst), .AWADDR_I(awa),
    .AWVALID_I(aw_v), .AWREADY_O(aw_rdy), .WDATA_I(wd),
    .WSTRB_I(stb), .WVALID_I(w_v), .WREADY_O(w_rdy),
    .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(b_r),
    .ARADDR_I(ara), .ARVALID_I(ar_v), .ARREADY_O(ar_rdy),
    .RDATA_O(rd), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(r_r),
    .RX_LEVEL_I(rxl), .TX_LEVEL_I(~rxl), .EXT_MODE_I(ext),
    .EXT_IR_MODE_I(extm), .LOOPBACK_I(lpb), .MODEM_STATUS_I(msi),
    .TX_ACTIVE_I(txa), .IR_RX_PRI_I(pri), .IR_RX_AUX_I(aux),
    .IR_MODE_O(mode), .CARRIER_MOD_EN_O(mod_en),
    .CARRIER_DEMOD_EN_O(dem_en), .SIR_PULSE_WIDTH_CONTROL_1U6_O(pw),
    .MSR_VALUE_O(modem_status_register), .MS_INT_EN_O(msi_en), .IR_RX_O(irx),
    .BANK_O(bank), .LINE_CONTROL_O(line_control_register));
  uib_ir_front i_front (.clk_i(clk), .rst_n_i(nrst), .pri_o(pri),
    .aux_o(aux));
  // ==========
  // clock, line history and hang guard
  always #12.5 clk = ~clk;
  // inputs seen at the last edge, the one the output flops sampled
  always @(posedge clk)
  begin
    pri_q <= pri;
    aux_q <= aux;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      if (!ta && aw_rdy)
      begin
        ta = 1'b1;
        aw_v <= 1'b0;
      end
      if (!tw && w_rdy)
      begin
        tw = 1'b1;
        w_v <= 1'b0;
      end
    end
    b_r <= 1'b1;
    do @(posedge clk); while (!bv);
    b_r <= 1'b0;
    chk("bresp", (a[7:5] != 3'h0) ? 2'b11 : 2'b00, bresp);
  endtask
  // the master stalls a cycle so the answer must stand
  task automatic rdc(input logic [7:0] a, e);
    @(posedge clk);
    ara <= a;
    ar_v <= 1'b1;
    do @(posedge clk); while (!ar_rdy);
    ar_v <= 1'b0;
    @(posedge clk);
    r_r <= 1'b1;
    do @(posedge clk); while (!rv);
    r_r <= 1'b0;
    chk("rdata", {24'h0, e}, rd);
    chk("rresp", (a[7:5] != 3'h0) ? 2'b11 : 2'b00, rresp);
  endtask
  task automatic settle(input string s);
    repeat (2) @(posedge clk);
    @(negedge clk);
    $display("test %s done", s);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    foreach (tbl[i])
      if (tbl[i][16])
        wr(tbl[i][15:8], tbl[i][7:0]);
      else
        rdc(tbl[i][15:8], tbl[i][7:0]);
    settle("table");
    @(posedge clk);
    rxl <= 5'h1f;
    repeat (3) rdc(8'h1c, 8'h1f);
    wr(8'h0c, 8'he4);
    wr(8'h08, 8'h08);
    settle("carrier");
    chk("mode", 2'b10, mode);
    chk("mod", 1'b0, mod_en);
    chk("dem", 1'b0, dem_en);
    wr(8'h0c, 8'he6);
    wr(8'h00, 8'h00);
    settle("carrier on");
    chk("mod", 1'b1, mod_en);
    chk("dem", 1'b1, dem_en);
    wr(8'h0c, 8'he4);
    wr(8'h08, 8'h0c);
    settle("sir");
    chk("mode", 2'b11, mode);
    chk("pw", 1'b1, pw);
    chk("msr", 8'h30, modem_status_register);
    chk("msint", 1'b0, msi_en);
    chk("rx aux", aux_q, irx);
    @(posedge clk);
    lpb <= 1'b1;
    settle("loopback");
    chk("msint lb", 1'b0, msi_en);
    chk("msr lb", 8'h30, modem_status_register);
    @(posedge clk);
    lpb <= 1'b0;
    txa <= 1'b1;
    wr(8'h0c, 8'he5);
    wr(8'h10, 8'h00);
    settle("half duplex");
    chk("msr", msi, modem_status_register);
    chk("msint", 1'b1, msi_en);
    chk("rx mask", 1'b0, irx);
    wr(8'h10, 8'h01);
    settle("full duplex");
    chk("rx fdx", pri_q, irx);
    @(posedge clk);
    txa <= 1'b0;
    settle("idle tx");
    chk("rx pri", pri_q, irx);
    @(posedge clk);
    ext <= 1'b1;
    settle("extended");
    chk("mode", 2'b01, mode);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    settle("reset");
    chk("lcr", 8'h00, line_control_register);
    chk("bank", 3'h0, bank);
    chk("pw", 1'b0, pw);
    wr(8'h0c, 8'he6);
    rdc(8'h00, 8'h20);
    stb <= 4'h0;
    wr(8'h0c, 8'h55);
    stb <= 4'h1;
    settle("lane off");
    chk("lcr", 8'h00, line_control_register);
    chk("bank", 3'h6, bank);
    wrap_up();
  end
endmodule
